//--- verilog/irq_pkg.sv
package irq_pkg;
  // ************************************************************
  // register addresses on the special function register port
  // ************************************************************
  localparam logic [7:0] ADDR_SEC_ENABLE   = 8'ha7;
  localparam logic [7:0] ADDR_PRI_ENABLE   = 8'ha8;
  localparam logic [7:0] ADDR_SEC_PRIORITY = 8'hb7;
  localparam logic [7:0] ADDR_PRI_PRIORITY = 8'hb8;

  // reset values and writable-bit masks (unused bits read zero)
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] PRI_EN_MASK   = 8'hbf;
  localparam logic [7:0] PRI_PRIO_MASK = 8'h3f;
  localparam logic [7:0] SEC_MASK      = 8'h13;

  // ************************************************************
  // bit positions in the primary and secondary registers
  // ************************************************************
  localparam int BIT_EXT_A    = 0;
  localparam int BIT_TIMER_A  = 1;
  localparam int BIT_EXT_B    = 2;
  localparam int BIT_TIMER_B  = 3;
  localparam int BIT_SERIAL_1 = 4;
  localparam int BIT_TIMER_C  = 5;
  localparam int BIT_GLOBAL   = 7;
  localparam int BIT_USB      = 0;
  localparam int BIT_I2C      = 1;
  localparam int BIT_SERIAL_2 = 4;

  // ************************************************************
  // sources in polling order, index 0 polled first
  // ************************************************************
  localparam int NUM_SRC = 10;
  localparam int SRC_W   = 4;
  typedef logic [NUM_SRC-1:0] src_vec_t;
  typedef logic [SRC_W-1:0]   src_idx_t;
  localparam src_idx_t SRC_EXT_A    = 4'h0;
  localparam src_idx_t SRC_SERIAL_2 = 4'h1;
  localparam src_idx_t SRC_TIMER_A  = 4'h2;
  localparam src_idx_t SRC_I2C      = 4'h3;
  localparam src_idx_t SRC_EXT_B    = 4'h4;
  localparam src_idx_t SRC_RESERVED = 4'h5;
  localparam src_idx_t SRC_TIMER_B  = 4'h6;
  localparam src_idx_t SRC_USB      = 4'h7;
  localparam src_idx_t SRC_SERIAL_1 = 4'h8;
  localparam src_idx_t SRC_TIMER_C  = 4'h9;

  // usb event flag positions
  localparam int USB_W        = 6;
  localparam int USB_EP0_TX   = 0;
  localparam int USB_EP0_RX   = 1;
  localparam int USB_EP12_TX  = 2;
  localparam int USB_SUSPEND  = 3;
  localparam int USB_RESUME   = 4;
  localparam int USB_EOP      = 5;

  // software clear strobe positions for timer control flags
  localparam int CLR_EXT_A   = 0;
  localparam int CLR_EXT_B   = 1;
  localparam int CLR_TIMER_A = 2;
  localparam int CLR_TIMER_B = 3;
  localparam int CLR_TC_OVF  = 0;
  localparam int CLR_TC_EXT  = 1;
endpackage

//--- verilog/pin_sampler.sv
`timescale 1ns/100ps
module pin_sampler (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // raw pin
  input  wire logic pin_i,
  // filtered level and falling-edge pulse
  output logic      level_o,
  output logic      fall_o
);
  logic s1_q, s2_q, s3_q;
  logic level_d, fall_d;

  // ************************************************************
  // three-stage synchroniser, change taken once stages 2 and 3 agree
  // ************************************************************
  always_comb begin
    level_d = level_o;
    fall_d  = 1'b0;
    if (s2_q == s3_q) begin
      level_d = s3_q;
      fall_d  = level_o & ~s3_q; // idle-high pins, act on the fall
    end
  end

  // pins idle high, so reset to high to avoid a false edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_o <= 1'b1;
      fall_o  <= 1'b0;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= level_d;
      fall_o  <= fall_d;
    end
  end
endmodule // pin_sampler

//--- verilog/interrupt_request_logic.sv
// Functional notes
// - nine sources plus one reserved slot: two pins, three timers, i2c, usb, two serial ports.
// - ext a is level or edge by its trigger select, held in flag.
// - ext b is level or edge by its own select, held in flag.
// - edge-mode ext flag clears on vectoring; level-mode flag does not.
// - level-mode flag follows pin; source must drop before routine ends.
// - timer a/b overflow sets flag, except timer a in split mode.
// - timer a/b overflow flags clear when their interrupt is serviced.
// - timer c overflow sets flag; only software clears it.
// - timer c external input, gated by enable, sets external flag too.
// - i2c request from its status flag, cleared by hardware on vector.
// - adc completion drives the ext b request when selected in edge mode.
// - usb raised on ep0 tx/rx, ep1/2 tx, suspend, resume, eop.
// - usb flags stay set until software clears them.
// - each serial request is rx-done or tx-done.
// - serial flags are left set; software clears the cause.
// - serial two enable and priority at bit 4 of secondary regs.
// - each source has own enable; global enable off blocks all.
// - one priority bit each; high preempts low, nothing preempts high.
// - equal priority resolved by fixed polling order, ext a first.
// - flags sampled per machine cycle, polled next; no memory.
`timescale 1ns/100ps
module interrupt_request_logic (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // special function register port
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic [7:0]            sfr_wdata_i,
  output logic [7:0]                 sfr_rdata_o,
  output logic                       sfr_hit_o,
  // external pins and adc
  input  wire logic                  ext_request_a_n_i,
  input  wire logic                  ext_request_b_n_i,
  input  wire logic                  ext_a_trigger_select_i,
  input  wire logic                  ext_b_trigger_select_i,
  input  wire logic                  adc_select_i,
  input  wire logic                  adc_done_i,
  // timers
  input  wire logic                  timer_a_overflow_i,
  input  wire logic                  timer_a_split_mode_i,
  input  wire logic                  timer_b_overflow_i,
  input  wire logic                  timer_c_overflow_i,
  input  wire logic                  timer_c_external_input_i,
  input  wire logic                  timer_c_external_enable_i,
  input  wire logic [3:0]            timer_control_reg_flag_clear_i,
  input  wire logic [1:0]            timer_c_flag_clear_i,
  // i2c, usb, serial
  input  wire logic                  i2c_irq_flag_i,
  input  wire logic [5:0]            usb_event_i,
  input  wire logic [5:0]            usb_flag_clear_i,
  input  wire logic                  serial_one_rx_done_flag_i,
  input  wire logic                  serial_one_tx_done_flag_i,
  input  wire logic                  serial_two_rx_done_flag_i,
  input  wire logic                  serial_two_tx_done_flag_i,
  // sequencer side
  input  wire logic                  sample_strobe_i,
  input  wire logic                  vector_ack_i,
  input  wire logic [3:0]            vector_src_i,
  input  wire logic                  reti_i,
  // flag outputs
  output logic                       ext_a_request_flag_o,
  output logic                       ext_b_request_flag_o,
  output logic                       timer_a_overflow_flag_o,
  output logic                       timer_b_overflow_flag_o,
  output logic                       timer_c_overflow_flag_o,
  output logic                       timer_c_external_flag_o,
  output logic [5:0]                 usb_flags_o,
  output logic                       i2c_flag_clear_o,
  // requests to the sequencer
  output logic [9:0]                 irq_pending_o,
  output logic [9:0]                 irq_level_o,
  output logic                       irq_req_o,
  output logic [3:0]                 irq_src_o,
  output logic                       irq_high_o,
  output logic [1:0]                 in_service_o
);
  // ************************************************************
  // polling order helpers
  // ************************************************************
  // first set bit in polling order
  function automatic irq_pkg::src_idx_t first_src(irq_pkg::src_vec_t v);
    first_src = '0;
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) first_src = irq_pkg::SRC_W'(i);
    end
  endfunction

  // spread primary/secondary register bits onto the polling order
  function automatic irq_pkg::src_vec_t by_src(logic [7:0] p,
                                               logic [7:0] s);
    by_src = '0;
    by_src[irq_pkg::SRC_EXT_A]    = p[irq_pkg::BIT_EXT_A];
    by_src[irq_pkg::SRC_SERIAL_2] = s[irq_pkg::BIT_SERIAL_2];
    by_src[irq_pkg::SRC_TIMER_A]  = p[irq_pkg::BIT_TIMER_A];
    by_src[irq_pkg::SRC_I2C]      = s[irq_pkg::BIT_I2C];
    by_src[irq_pkg::SRC_EXT_B]    = p[irq_pkg::BIT_EXT_B];
    by_src[irq_pkg::SRC_TIMER_B]  = p[irq_pkg::BIT_TIMER_B];
    by_src[irq_pkg::SRC_USB]      = s[irq_pkg::BIT_USB];
    by_src[irq_pkg::SRC_SERIAL_1] = p[irq_pkg::BIT_SERIAL_1];
    by_src[irq_pkg::SRC_TIMER_C]  = p[irq_pkg::BIT_TIMER_C];
  endfunction

  // ************************************************************
  // pin sampling
  // ************************************************************
  logic ext_a_level, ext_a_fall, ext_b_level, ext_b_fall;
  logic tc_ext_level, tc_ext_fall;

  pin_sampler u_ext_a (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_request_a_n_i),
    .level_o   (ext_a_level),
    .fall_o    (ext_a_fall)
  );
  pin_sampler u_ext_b (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_request_b_n_i),
    .level_o   (ext_b_level),
    .fall_o    (ext_b_fall)
  );
  pin_sampler u_tc_ext (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (timer_c_external_input_i),
    .level_o   (tc_ext_level),
    .fall_o    (tc_ext_fall)
  );

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] pri_en_q, pri_en_d, sec_en_q, sec_en_d;
  logic [7:0] pri_pr_q, pri_pr_d, sec_pr_q, sec_pr_d;
  logic [7:0] rdata_d;
  logic       hit_d;

  // unused bits are masked on write so they always read zero
  always_comb begin
    pri_en_d = pri_en_q;
    sec_en_d = sec_en_q;
    pri_pr_d = pri_pr_q;
    sec_pr_d = sec_pr_q;
    rdata_d  = '0;
    hit_d    = 1'b1;
    unique case (sfr_addr_i)
      irq_pkg::ADDR_PRI_ENABLE: begin
        rdata_d = pri_en_q;
        if (sfr_wr_i) pri_en_d = sfr_wdata_i & irq_pkg::PRI_EN_MASK;
      end
      irq_pkg::ADDR_SEC_ENABLE: begin
        rdata_d = sec_en_q;
        if (sfr_wr_i) sec_en_d = sfr_wdata_i & irq_pkg::SEC_MASK;
      end
      irq_pkg::ADDR_PRI_PRIORITY: begin
        rdata_d = pri_pr_q;
        if (sfr_wr_i) pri_pr_d = sfr_wdata_i & irq_pkg::PRI_PRIO_MASK;
      end
      irq_pkg::ADDR_SEC_PRIORITY: begin
        rdata_d = sec_pr_q;
        if (sfr_wr_i) sec_pr_d = sfr_wdata_i & irq_pkg::SEC_MASK;
      end
      default: hit_d = 1'b0; // other addresses belong elsewhere
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pri_en_q    <= irq_pkg::REG_RESET;
      sec_en_q    <= irq_pkg::REG_RESET;
      pri_pr_q    <= irq_pkg::REG_RESET;
      sec_pr_q    <= irq_pkg::REG_RESET;
      sfr_rdata_o <= irq_pkg::REG_RESET;
      sfr_hit_o   <= 1'b0;
    end else begin
      pri_en_q    <= pri_en_d;
      sec_en_q    <= sec_en_d;
      pri_pr_q    <= pri_pr_d;
      sec_pr_q    <= sec_pr_d;
      sfr_rdata_o <= rdata_d;
      sfr_hit_o   <= hit_d;
    end
  end

  // ************************************************************
  // request flags
  // ************************************************************
  logic ack_ext_a, ack_ext_b, ack_tim_a, ack_tim_b, ack_i2c;
  logic ext_a_d, ext_b_d, tim_a_d, tim_b_d, tc_ovf_d, tc_ext_d;
  logic ext_b_event, ext_b_low;
  logic [5:0] usb_d;

  assign ack_ext_a = vector_ack_i && vector_src_i == irq_pkg::SRC_EXT_A;
  assign ack_ext_b = vector_ack_i && vector_src_i == irq_pkg::SRC_EXT_B;
  assign ack_tim_a = vector_ack_i
                     && vector_src_i == irq_pkg::SRC_TIMER_A;
  assign ack_tim_b = vector_ack_i
                     && vector_src_i == irq_pkg::SRC_TIMER_B;
  assign ack_i2c   = vector_ack_i && vector_src_i == irq_pkg::SRC_I2C;
  // adc takes the ext b line over when selected
  assign ext_b_event = adc_select_i ? adc_done_i : ext_b_fall;
  assign ext_b_low   = adc_select_i ? 1'b0 : ~ext_b_level;

  // new events always win over a clear in the same cycle
  always_comb begin
    ext_a_d  = ext_a_request_flag_o;
    ext_b_d  = ext_b_request_flag_o;
    if (!ext_a_trigger_select_i) begin
      ext_a_d = ~ext_a_level;
    end else if (ext_a_fall) begin
      ext_a_d = 1'b1;
    end else if (ack_ext_a || timer_control_reg_flag_clear_i[irq_pkg::CLR_EXT_A]) begin
      ext_a_d = 1'b0;
    end
    if (!ext_b_trigger_select_i) begin
      ext_b_d = ext_b_low;
    end else if (ext_b_event) begin
      ext_b_d = 1'b1;
    end else if (ack_ext_b || timer_control_reg_flag_clear_i[irq_pkg::CLR_EXT_B]) begin
      ext_b_d = 1'b0;
    end
    tim_a_d = timer_a_overflow_flag_o;
    if (timer_a_overflow_i && !timer_a_split_mode_i) begin
      tim_a_d = 1'b1;
    end else if (ack_tim_a || timer_control_reg_flag_clear_i[irq_pkg::CLR_TIMER_A]) begin
      tim_a_d = 1'b0;
    end
    tim_b_d = timer_b_overflow_flag_o;
    if (timer_b_overflow_i) begin
      tim_b_d = 1'b1;
    end else if (ack_tim_b || timer_control_reg_flag_clear_i[irq_pkg::CLR_TIMER_B]) begin
      tim_b_d = 1'b0;
    end
    // timer c flags ignore vectoring entirely
    tc_ovf_d = timer_c_overflow_flag_o;
    if (timer_c_overflow_i) begin
      tc_ovf_d = 1'b1;
    end else if (timer_c_flag_clear_i[irq_pkg::CLR_TC_OVF]) begin
      tc_ovf_d = 1'b0;
    end
    tc_ext_d = timer_c_external_flag_o;
    if (tc_ext_fall && timer_c_external_enable_i) begin
      tc_ext_d = 1'b1;
    end else if (timer_c_flag_clear_i[irq_pkg::CLR_TC_EXT]) begin
      tc_ext_d = 1'b0;
    end
    // usb flags: set by events, cleared only by software
    usb_d = (usb_flags_o & ~usb_flag_clear_i) | usb_event_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_a_request_flag_o    <= 1'b0;
      ext_b_request_flag_o    <= 1'b0;
      timer_a_overflow_flag_o <= 1'b0;
      timer_b_overflow_flag_o <= 1'b0;
      timer_c_overflow_flag_o <= 1'b0;
      timer_c_external_flag_o <= 1'b0;
      usb_flags_o             <= '0;
      i2c_flag_clear_o        <= 1'b0;
    end else begin
      ext_a_request_flag_o    <= ext_a_d;
      ext_b_request_flag_o    <= ext_b_d;
      timer_a_overflow_flag_o <= tim_a_d;
      timer_b_overflow_flag_o <= tim_b_d;
      timer_c_overflow_flag_o <= tc_ovf_d;
      timer_c_external_flag_o <= tc_ext_d;
      usb_flags_o             <= usb_d;
      i2c_flag_clear_o        <= ack_i2c;
    end
  end

  // ************************************************************
  // sampling, polling and preemption
  // ************************************************************
  irq_pkg::src_vec_t live, enabled, levels, elig, hi_c, lo_c;
  irq_pkg::src_vec_t pend_d;
  logic       req_d, high_d;
  logic [3:0] src_d;
  logic [1:0] serv_d;

  // one vector entry per source in polling order
  always_comb begin
    live = '0;
    live[irq_pkg::SRC_EXT_A]    = ext_a_request_flag_o;
    live[irq_pkg::SRC_SERIAL_2] = serial_two_rx_done_flag_i
                                  | serial_two_tx_done_flag_i;
    live[irq_pkg::SRC_TIMER_A]  = timer_a_overflow_flag_o;
    live[irq_pkg::SRC_I2C]      = i2c_irq_flag_i;
    live[irq_pkg::SRC_EXT_B]    = ext_b_request_flag_o;
    live[irq_pkg::SRC_TIMER_B]  = timer_b_overflow_flag_o;
    live[irq_pkg::SRC_USB]      = |usb_flags_o;
    live[irq_pkg::SRC_SERIAL_1] = serial_one_rx_done_flag_i
                                  | serial_one_tx_done_flag_i;
    live[irq_pkg::SRC_TIMER_C]  = timer_c_overflow_flag_o
                                  | timer_c_external_flag_o;
    enabled = by_src(pri_en_q, sec_en_q)
              & {irq_pkg::NUM_SRC{pri_en_q[irq_pkg::BIT_GLOBAL]}};
    levels  = by_src(pri_pr_q, sec_pr_q);
  end

  // fresh sample each strobe, so a dropped flag is forgotten
  always_comb begin
    pend_d = irq_pending_o;
    if (sample_strobe_i) pend_d = live & enabled;
    elig   = irq_pending_o;
    hi_c   = elig & irq_level_o;
    lo_c   = elig & ~irq_level_o;
    req_d  = 1'b0;
    high_d = 1'b0;
    src_d  = irq_src_o;
    // a running high routine blocks all; a low one blocks low only
    if (!in_service_o[1] && |hi_c) begin
      req_d  = 1'b1;
      high_d = 1'b1;
      src_d  = first_src(hi_c);
    end else if (!in_service_o[1] && !in_service_o[0] && |lo_c) begin
      req_d  = 1'b1;
      src_d  = first_src(lo_c);
    end
    if (vector_ack_i) req_d = 1'b0; // no repeat while core vectors
    serv_d = in_service_o;
    if (reti_i) begin
      if (in_service_o[1]) serv_d[1] = 1'b0;
      else serv_d[0] = 1'b0;
    end
    if (vector_ack_i) begin
      if (irq_level_o[vector_src_i]) serv_d[1] = 1'b1;
      else serv_d[0] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_pending_o <= '0;
      irq_level_o   <= '0;
      irq_req_o     <= 1'b0;
      irq_src_o     <= '0;
      irq_high_o    <= 1'b0;
      in_service_o  <= '0;
    end else begin
      irq_pending_o <= pend_d;
      irq_level_o   <= levels;
      irq_req_o     <= req_d;
      irq_src_o     <= src_d;
      irq_high_o    <= high_d;
      in_service_o  <= serv_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_edge_ack_a;
    ext_a_trigger_select_i && ack_ext_a && !ext_a_fall;
  endsequence

  a_edge_ack_clear: assert property (
    s_edge_ack_a |=> !ext_a_request_flag_o)
    else $error("edge flag a not cleared on vector");
  a_level_follow: assert property (
    !ext_a_trigger_select_i
    |=> ext_a_request_flag_o == !$past(ext_a_level))
    else $error("level flag a does not follow pin");
  a_split_mode: assert property (
    timer_a_split_mode_i && !timer_a_overflow_flag_o
    |=> !timer_a_overflow_flag_o)
    else $error("timer a flag set in split mode");
  a_tim_b_ack: assert property (
    ack_tim_b && !timer_b_overflow_i |=> !timer_b_overflow_flag_o)
    else $error("timer b flag kept after service");
  a_tc_sw_only: assert property (
    timer_c_overflow_flag_o
    && !timer_c_flag_clear_i[irq_pkg::CLR_TC_OVF]
    |=> timer_c_overflow_flag_o)
    else $error("timer c flag cleared without software");
  a_usb_hold: assert property (
    usb_flags_o[irq_pkg::USB_EOP]
    && !usb_flag_clear_i[irq_pkg::USB_EOP]
    |=> usb_flags_o[irq_pkg::USB_EOP])
    else $error("usb flag dropped without clear");
  a_global_off: assert property (
    sample_strobe_i && !pri_en_q[irq_pkg::BIT_GLOBAL]
    |=> irq_pending_o == '0 ##1 !irq_req_o)
    else $error("request passed with global enable off");
  a_high_block: assert property (in_service_o[1] |=> !irq_req_o)
    else $error("request raised during high routine");
  a_i2c_clear: assert property (ack_i2c |=> i2c_flag_clear_o)
    else $error("i2c clear pulse missing");
endmodule // interrupt_request_logic

//--- test/seq_partner.sv
`timescale 1ns/100ps
module seq_partner (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // requests from the block
  input  wire logic       irq_req_i,
  input  wire logic [3:0] irq_src_i,
  // sequencer strobes
  output logic            sample_strobe_o,
  output logic            vector_ack_o,
  output logic [3:0]      vector_src_o,
  output logic            reti_o
);
  logic [3:0] cnt_q;
  logic [3:0] svc_q;

  // quiet start
  initial begin
    {cnt_q, svc_q, sample_strobe_o, vector_ack_o, reti_o} = '0;
    vector_src_o = 4'h0;
  end

  // machine cycle is four clocks; acks at once, returns six later
  always @(negedge clk_sys_i) begin
    cnt_q = rst_n_i ? cnt_q + 4'h1 : 4'h0;
    sample_strobe_o = (cnt_q[1:0] == 2'h0);
    vector_ack_o = rst_n_i && irq_req_i === 1'b1 && !vector_ack_o;
    // src is junk outside an ack, inverted each clock rather than held
    vector_src_o = vector_ack_o ? irq_src_i : ~vector_src_o;
    reti_o = (svc_q == 4'h1);
    svc_q = vector_ack_o ? 4'h6 : (svc_q != 4'h0) ? svc_q - 4'h1 : 4'h0;
  end
endmodule // seq_partner

//--- test/interrupt_request_logic_tb_top.sv
`timescale 1ns/100ps
module interrupt_request_logic_tb_top;
  logic clk_sys_i, rst_n_i, sfr_wr_i, sfr_hit_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic ext_request_a_n_i, ext_request_b_n_i, ext_a_trigger_select_i;
  logic ext_b_trigger_select_i, adc_select_i, adc_done_i;
  logic timer_a_overflow_i, timer_a_split_mode_i, timer_b_overflow_i;
  logic timer_c_overflow_i, timer_c_external_input_i;
  logic timer_c_external_enable_i, i2c_irq_flag_i, i2c_flag_clear_o;
  logic [3:0] timer_control_reg_flag_clear_i, vector_src_i, irq_src_o;
  logic [1:0] timer_c_flag_clear_i, in_service_o;
  logic serial_one_rx_done_flag_i, serial_one_tx_done_flag_i;
  logic serial_two_rx_done_flag_i, serial_two_tx_done_flag_i;
  logic [5:0] usb_event_i, usb_flag_clear_i, usb_flags_o;
  logic sample_strobe_i, vector_ack_i, reti_i, irq_req_o, irq_high_o;
  logic ext_a_request_flag_o, ext_b_request_flag_o;
  logic timer_a_overflow_flag_o, timer_b_overflow_flag_o;
  logic timer_c_overflow_flag_o, timer_c_external_flag_o;
  logic [9:0] irq_pending_o, irq_level_o;
  int n_fail, num_checks, cyc;

  interrupt_request_logic i_interrupt_request_logic (.*);
  seq_partner i_seq_partner (.clk_sys_i, .rst_n_i, .irq_req_i(irq_req_o),
    .irq_src_i(irq_src_o), .sample_strobe_o(sample_strobe_i),
    .vector_ack_o(vector_ack_i), .vector_src_o(vector_src_i),
    .reti_o(reti_i));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    cyc_n(1);
    sfr_wr_i = 1'b0;
    cyc_n(1); // idle edge keeps back-to-back strobes apart
  endtask
  // read data is registered, so look one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr_addr_i = a;
    cyc_n(1);
    chk({1'b0, sfr_hit_o, sfr_rdata_o}, {1'b0, h, e});
  endtask
  // bounded wait, then the winning source index
  task automatic wait_req(input logic [3:0] src);
    int i;
    i = 0;
    while (irq_req_o !== 1'b1 && i < 40) begin
      cyc_n(1);
      i++;
    end
    chk({5'h0, irq_req_o, irq_src_o}, {5'h0, 1'b1, src});
  endtask

  task automatic t_regs;
    logic [7:0] ad [4] = '{8'ha7, 8'ha8, 8'hb7, 8'hb8};
    logic [7:0] mk [4] = '{8'h13, 8'hbf, 8'h13, 8'h3f};
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], 8'h00, 1'b1);
      wr(ad[i], 8'hff);
      rd(ad[i], mk[i], 1'b1);
      wr(ad[i], 8'h00);
    end
    rd(8'h55, 8'h00, 1'b0);
    $display("test regs done");
  endtask
  task automatic t_timers;
    timer_a_split_mode_i = 1'b1;
    wr(8'ha8, 8'h8a);
    {timer_a_overflow_i, timer_b_overflow_i} = 2'h3;
    cyc_n(1);
    {timer_a_overflow_i, timer_b_overflow_i, timer_a_split_mode_i} = '0;
    chk({8'h0, timer_a_overflow_flag_o, timer_b_overflow_flag_o},
        10'h1);
    wait_req(4'h6);
    cyc_n(3);
    chk({8'h0, timer_b_overflow_flag_o, in_service_o[0]}, 10'h1);
    wr(8'ha8, 8'ha0);
    cyc_n(8);
    chk({8'h0, in_service_o}, 10'h0);
    timer_c_overflow_i = 1'b1;
    cyc_n(1);
    timer_c_overflow_i = 1'b0;
    wait_req(4'h9);
    cyc_n(8);
    chk({9'h0, timer_c_overflow_flag_o}, 10'h1);
    timer_c_flag_clear_i = 2'h1;
    wr(8'ha8, 8'h00);
    timer_c_flag_clear_i = 2'h0;
    chk({9'h0, timer_c_overflow_flag_o}, 10'h0);
    cyc_n(8);
    $display("test timers done");
  endtask
  task automatic t_usb;
    wr(8'ha7, 8'h01);
    wr(8'ha8, 8'h80);
    usb_event_i = 6'h20;
    cyc_n(1);
    usb_event_i = 6'h00;
    wait_req(4'h7);
    cyc_n(4);
    chk({4'h0, usb_flags_o}, 10'h20);
    usb_flag_clear_i = 6'h20;
    wr(8'ha8, 8'h00);
    usb_flag_clear_i = 6'h00;
    chk({4'h0, usb_flags_o}, 10'h0);
    wr(8'ha7, 8'h00);
    cyc_n(8);
    $display("test usb done");
  endtask
  task automatic t_pins;
    // edge mode, high level: vectoring clears the flag
    ext_a_trigger_select_i = 1'b1;
    wr(8'hb8, 8'h01);
    wr(8'ha8, 8'h81);
    ext_request_a_n_i = 1'b0;
    cyc_n(5); // three sync stages, filter, then the flag
    chk({9'h0, ext_a_request_flag_o}, 10'h1);
    ext_request_a_n_i = 1'b1;
    wait_req(4'h0);
    chk(irq_pending_o, 10'h001);
    chk(irq_level_o, 10'h001);
    cyc_n(1);
    chk({9'h0, ext_a_request_flag_o}, 10'h0);
    // level mode: flag survives vectoring, follows the pin
    ext_a_trigger_select_i = 1'b0;
    ext_request_a_n_i = 1'b0;
    wait_req(4'h0);
    cyc_n(1);
    chk({9'h0, ext_a_request_flag_o}, 10'h1);
    ext_request_a_n_i = 1'b1;
    cyc_n(5);
    chk({9'h0, ext_a_request_flag_o}, 10'h0);
    wr(8'ha8, 8'h00);
    // adc owns the ext b line in edge mode
    ext_b_trigger_select_i = 1'b1;
    adc_select_i = 1'b1;
    adc_done_i = 1'b1;
    cyc_n(1);
    adc_done_i = 1'b0;
    chk({9'h0, ext_b_request_flag_o}, 10'h1);
    timer_control_reg_flag_clear_i = 4'h2;
    cyc_n(1);
    timer_control_reg_flag_clear_i = 4'h0;
    chk({9'h0, ext_b_request_flag_o}, 10'h0);
    // timer c external input, refused while its enable is off
    timer_c_external_input_i = 1'b0;
    cyc_n(6);
    chk({9'h0, timer_c_external_flag_o}, 10'h0);
    timer_c_external_input_i = 1'b1;
    timer_c_external_enable_i = 1'b1;
    cyc_n(6);
    timer_c_external_input_i = 1'b0;
    cyc_n(5);
    chk({9'h0, timer_c_external_flag_o}, 10'h1);
    timer_c_flag_clear_i = 2'h2;
    cyc_n(1);
    timer_c_flag_clear_i = 2'h0;
    chk({9'h0, timer_c_external_flag_o}, 10'h0);
    // i2c: one clear pulse right after vectoring
    wr(8'ha7, 8'h02);
    wr(8'ha8, 8'h80);
    i2c_irq_flag_i = 1'b1;
    wait_req(4'h3);
    cyc_n(1);
    chk({9'h0, i2c_flag_clear_o}, 10'h1);
    i2c_irq_flag_i = 1'b0; // the i2c block obeys the pulse
    cyc_n(1);
    chk({9'h0, i2c_flag_clear_o}, 10'h0);
    wr(8'ha8, 8'h00);
    wr(8'ha7, 8'h00);
    $display("test pins done");
  endtask
  task automatic t_order;
    serial_one_tx_done_flag_i = 1'b1;
    serial_two_rx_done_flag_i = 1'b1;
    wr(8'ha7, 8'h10);
    wr(8'ha8, 8'h90);
    wait_req(4'h1);
    wr(8'ha8, 8'h00);
    cyc_n(8);
    wr(8'hb8, 8'h10);
    wr(8'ha8, 8'h90);
    wait_req(4'h8);
    chk({9'h0, irq_high_o}, 10'h1);
    wr(8'ha8, 8'h00);
    $display("test order done");
  endtask

  // free-running clock, 8 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // main sequence; pins idle high
  initial begin
    {n_fail, num_checks, cyc} = '0;
    {rst_n_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i} = '0;
    {ext_request_a_n_i, ext_request_b_n_i} = 2'h3;
    {ext_a_trigger_select_i, ext_b_trigger_select_i} = 2'h0;
    {adc_select_i, adc_done_i, i2c_irq_flag_i} = 3'h0;
    {timer_a_overflow_i, timer_a_split_mode_i, timer_b_overflow_i} = 3'h0;
    {timer_c_overflow_i, timer_c_external_enable_i} = 2'h0;
    timer_c_external_input_i = 1'b1;
    {timer_control_reg_flag_clear_i, timer_c_flag_clear_i} = '0;
    {usb_event_i, usb_flag_clear_i} = '0;
    {serial_one_rx_done_flag_i, serial_one_tx_done_flag_i} = 2'h0;
    {serial_two_rx_done_flag_i, serial_two_tx_done_flag_i} = 2'h0;
    cyc_n(5);
    rst_n_i = 1'b1;
    cyc_n(6);
    t_regs();
    t_timers();
    t_usb();
    t_pins();
    t_order();
    tally_and_finish();
  end
endmodule // interrupt_request_logic_tb_top
